// file: verilog/tbh_dev.sv
// Button controller command port: bus target, pointer and registers
// Function
// - Command 08 enters setup mode
// - Command 07 returns to normal sensing
// - Command 02 reloads factory default registers
// - Command 06 software reset, from setup
// - Command 01 saves configuration to flash
// - Host waits save completion before next command
// - In setup, register 06 configures sense pins
// - Register 81 selects button for readback
// - Six bytes from 82: baseline, diff, raw
// - Byte at 88 returns touch status
// - First written byte loads pointer, rest data
// - Reads start at previously written pointer
// - Inputs reject spikes up to 50 ns
// - Host avoids save at 512/64 Hz sleep
`timescale 1ns/1ps
`include "tbh_regs.svh"
module tbh_dev
  import tbh_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link
  tbh_link_if.dev link,
  // Mode and command strobes
  output logic setup_mode,
  output logic defaults_pulse,
  output logic soft_reset_pulse,
  output logic flash_save_pulse,
  // Configuration
  output logic [7:0] input_config,
  output logic [7:0] button_select,
  // Scan results of the selected button
  input wire logic [15:0] baseline,
  input wire logic [15:0] diff_count,
  input wire logic [15:0] raw_count,
  input wire logic [7:0] touch_status
);
  typedef struct packed {
    tbh_dev_st_t st;
    logic [2:0] scl_cnt;
    logic [2:0] sda_cnt;
    logic scl_f;
    logic sda_f;
    logic scl_p;
    logic sda_p;
    logic [7:0] sh;
    logic [3:0] bitc;
    logic rw;
    logic first;
    logic addr_phase;
    logic [7:0] ptr;
    logic sda_oe;
    logic setup;
    logic dflt;
    logic swrst;
    logic save;
    logic [7:0] incfg;
    logic [7:0] btnsel;
  } tbh_dev_state_t;

  tbh_dev_state_t s_reg;
  tbh_dev_state_t s_next;

  // Read mux over the pointer
  function automatic logic [7:0] tbh_rd(input logic [7:0] p,
                                       input logic [7:0] cfg,
                                       input logic [7:0] sel);
    logic [7:0] r;
    r = 8'h00;
    case (p)
      `TBH_PTR_INCFG: r = cfg;
      `TBH_PTR_BTNSEL: r = sel;
      8'h82: r = baseline[15:8];
      8'h83: r = baseline[7:0];
      8'h84: r = diff_count[15:8];
      8'h85: r = diff_count[7:0];
      8'h86: r = raw_count[15:8];
      8'h87: r = raw_count[7:0];
      `TBH_PTR_STATUS: r = touch_status;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Spike filter: level accepted only after outlasting the longest spike
  function automatic logic [3:0] tbh_filt(input logic raw,
                                         input logic f,
                                         input logic [2:0] cnt);
    logic [3:0] r;
    r = {f, 3'b000};
    if (raw != f) begin
      if (cnt == 3'(`TBH_SPIKE_CYC + 1)) begin
        r = {raw, 3'b000};
      end else begin
        r = {f, 3'(cnt + 3'b001)};
      end
    end
    return r;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_comb begin
    s_next = s_reg;
    s_next.dflt = 1'b0;
    s_next.swrst = 1'b0;
    s_next.save = 1'b0;
    s_next.scl_p = s_reg.scl_f;
    s_next.sda_p = s_reg.sda_f;
    {s_next.scl_f, s_next.scl_cnt} =
      tbh_filt(link.scl, s_reg.scl_f, s_reg.scl_cnt);
    {s_next.sda_f, s_next.sda_cnt} =
      tbh_filt(link.sda, s_reg.sda_f, s_reg.sda_cnt);
    scl_rise = s_reg.scl_f && !s_reg.scl_p;
    scl_fall = !s_reg.scl_f && s_reg.scl_p;
    start_c = s_reg.scl_f && s_reg.scl_p && s_reg.sda_p && !s_reg.sda_f;
    stop_c = s_reg.scl_f && s_reg.scl_p && !s_reg.sda_p && s_reg.sda_f;
    if (start_c) begin
      s_next.st = TBH_D_RX;
      s_next.bitc = 4'h0;
      s_next.addr_phase = 1'b1;
      s_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_next.st = TBH_D_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      case (s_reg.st)
        TBH_D_RX: begin
          if (scl_rise) begin
            s_next.sh = {s_reg.sh[6:0], s_reg.sda_f};
            s_next.bitc = s_reg.bitc + 4'h1;
          end else if (scl_fall && s_reg.bitc == 4'h8) begin
            s_next.st = TBH_D_ACK;
            s_next.sda_oe = 1'b1;
            if (s_reg.addr_phase) begin
              s_next.rw = s_reg.sh[0];
              s_next.first = 1'b1;
              if (s_reg.sh[7:1] != `TBH_DEV_ADDR) begin
                s_next.st = TBH_D_WAIT;
                s_next.sda_oe = 1'b0;
              end
            end else if (s_reg.first) begin
              s_next.ptr = s_reg.sh;
              s_next.first = 1'b0;
            end else begin
              case (s_reg.ptr)
                `TBH_PTR_INCFG: begin
                  // Register writes change sense pins only while scanning is stopped
                  if (s_reg.setup) begin
                    s_next.incfg = s_reg.sh;
                  end
                end
                `TBH_PTR_BTNSEL: s_next.btnsel = s_reg.sh;
                `TBH_PTR_CMD: begin
                  case (s_reg.sh)
                    `TBH_CMD_SETUP: s_next.setup = 1'b1;
                    `TBH_CMD_NORMAL: s_next.setup = 1'b0;
                    `TBH_CMD_DEFAULTS: begin
                      s_next.incfg = `TBH_INCFG_RST;
                      s_next.btnsel = `TBH_BTNSEL_RST;
                      s_next.dflt = 1'b1;
                    end
                    `TBH_CMD_SAVE: s_next.save = 1'b1;
                    `TBH_CMD_SWRESET: begin
                      // Reset outside setup would cut a live scan
                      if (s_reg.setup) begin
                        s_next.swrst = 1'b1;
                        s_next.setup = 1'b0;
                      end
                    end
                    default: s_next.setup = s_reg.setup;
                  endcase
                end
                default: s_next.ptr = s_reg.ptr;
              endcase
            end
          end
        end
        TBH_D_ACK: begin
          if (scl_fall) begin
            s_next.addr_phase = 1'b0;
            s_next.bitc = 4'h0;
            if (s_reg.rw) begin
              s_next.sh = tbh_rd(s_reg.ptr, s_reg.incfg,
                                 s_reg.btnsel);
              s_next.st = TBH_D_TX;
              s_next.sda_oe = !s_next.sh[7];
            end else begin
              s_next.st = TBH_D_RX;
              s_next.sda_oe = 1'b0;
            end
          end
        end
        TBH_D_TX: begin
          if (scl_rise) begin
            s_next.sh = {s_reg.sh[6:0], 1'b0};
            s_next.bitc = s_reg.bitc + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.bitc == 4'h8) begin
              s_next.st = TBH_D_RACK;
              s_next.sda_oe = 1'b0;
            end else begin
              s_next.sda_oe = !s_reg.sh[7];
            end
          end
        end
        TBH_D_RACK: begin
          if (scl_rise) begin
            if (s_reg.sda_f) begin
              s_next.st = TBH_D_WAIT;
            end else begin
              s_next.ptr = s_reg.ptr + 8'h01;
              s_next.sh = tbh_rd(s_reg.ptr + 8'h01, s_reg.incfg,
                                 s_reg.btnsel);
              s_next.bitc = 4'h0;
            end
          end else if (scl_fall) begin
            s_next.st = TBH_D_TX;
            s_next.sda_oe = !s_reg.sh[7];
          end
        end
        TBH_D_IDLE, TBH_D_WAIT: s_next.sda_oe = 1'b0;
        default: s_next.st = TBH_D_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.scl_f <= 1'b1;
      s_reg.sda_f <= 1'b1;
      s_reg.scl_p <= 1'b1;
      s_reg.sda_p <= 1'b1;
      s_reg.incfg <= `TBH_INCFG_RST;
      s_reg.btnsel <= `TBH_BTNSEL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe = s_reg.sda_oe;
  assign setup_mode = s_reg.setup;
  assign defaults_pulse = s_reg.dflt;
  assign soft_reset_pulse = s_reg.swrst;
  assign flash_save_pulse = s_reg.save;
  assign input_config = s_reg.incfg;
  assign button_select = s_reg.btnsel;
endmodule

// file: verilog/tbh_regs.svh
// Register map, command codes and timing counts of the button host port
`ifndef TBH_REGS_SVH
`define TBH_REGS_SVH
`define TBH_DEV_ADDR 7'h00
`define TBH_PTR_INCFG 8'h06
`define TBH_PTR_BTNSEL 8'h81
`define TBH_PTR_SCAN 8'h82
`define TBH_PTR_STATUS 8'h88
`define TBH_PTR_CMD 8'ha0
`define TBH_SCAN_BYTES 8'h06
`define TBH_CMD_SAVE 8'h01
`define TBH_CMD_DEFAULTS 8'h02
`define TBH_CMD_SWRESET 8'h06
`define TBH_CMD_NORMAL 8'h07
`define TBH_CMD_SETUP 8'h08
`define TBH_INCFG_RST 8'h00
`define TBH_BTNSEL_RST 8'h00
`define TBH_CLK_NS 20
`define TBH_SPIKE_NS 50
`define TBH_SPIKE_CYC (`TBH_SPIKE_NS / `TBH_CLK_NS)
`define TBH_QTR_NS 2500
`define TBH_QTR_CYC ((`TBH_QTR_NS + `TBH_CLK_NS - 1) / `TBH_CLK_NS)
`define TBH_FLASH_WAIT_US 100000
`define TBH_FLASH_WAIT_CYC (`TBH_FLASH_WAIT_US * 1000 / `TBH_CLK_NS)
`endif

// file: verilog/tbh_pkg.sv
// Types shared by both ends of the button host port
package tbh_pkg;
  typedef enum logic [2:0] {
    TBH_D_IDLE = 3'b000,
    TBH_D_RX = 3'b001,
    TBH_D_ACK = 3'b010,
    TBH_D_TX = 3'b011,
    TBH_D_RACK = 3'b100,
    TBH_D_WAIT = 3'b101
  } tbh_dev_st_t;

  typedef enum logic [2:0] {
    TBH_H_IDLE = 3'b000,
    TBH_H_START = 3'b001,
    TBH_H_TX = 3'b010,
    TBH_H_TACK = 3'b011,
    TBH_H_RX = 3'b100,
    TBH_H_RACK = 3'b101,
    TBH_H_STOP = 3'b110,
    TBH_H_HOLD = 3'b111
  } tbh_host_st_t;
endpackage

// file: verilog/tbh_link_if.sv
// Two-wire link between the button controller and its host
`timescale 1ns/1ps
interface tbh_link_if;
  logic scl;
  logic sda;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;

  // Open-drain wires with pull-ups
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) ||
                 (dev_sda_oe && !dev_sda_out));

  modport host (input scl, input sda, output host_scl_out,
                output host_scl_oe, output host_sda_out,
                output host_sda_oe);
  modport dev (input scl, input sda, output dev_sda_out,
               output dev_sda_oe);
endinterface

// file: verilog/tbh_host.sv
// Bus host that issues register writes and reads to the controller
`timescale 1ns/1ps
`include "tbh_regs.svh"
module tbh_host
  import tbh_pkg::*;
#(
  parameter int FLASH_WAIT_CYC = `TBH_FLASH_WAIT_CYC
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link
  tbh_link_if.host link,
  // Request
  input wire logic req,
  input wire logic req_read,
  input wire logic [6:0] dev_addr,
  input wire logic [7:0] reg_ptr,
  input wire logic with_data,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_len,
  input wire logic sleep_rate_unsafe,
  // Answer
  output logic busy,
  output logic done,
  output logic refused,
  output logic nack_seen,
  output logic [7:0] rd_byte,
  output logic rd_valid
);
  typedef struct packed {
    tbh_host_st_t st;
    logic [6:0] qcnt;
    logic [1:0] q;
    logic [31:0] wait_cnt;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [2:0] left;
    logic [3:0] rleft;
    logic rd;
    logic [7:0] pend;
    logic setup_sent;
    logic long_wait;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic refused;
    logic nack;
    logic [7:0] rbyte;
    logic rvalid;
  } tbh_host_state_t;

  tbh_host_state_t s_reg;
  tbh_host_state_t s_next;
  logic tick;
  logic is_cmd;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.refused = 1'b0;
    s_next.rvalid = 1'b0;
    tick = s_reg.qcnt == 7'(`TBH_QTR_CYC - 1);
    s_next.qcnt = tick ? 7'h00 : s_reg.qcnt + 7'h01;
    is_cmd = !req_read && with_data && reg_ptr == `TBH_PTR_CMD;
    case (s_reg.st)
      TBH_H_IDLE: begin
        s_next.q = 2'b00;
        if (req) begin
          if (is_cmd && ((wr_data == `TBH_CMD_SAVE && sleep_rate_unsafe)
              || (wr_data == `TBH_CMD_SWRESET && !s_reg.setup_sent))) begin
            s_next.refused = 1'b1;
          end else begin
            s_next.st = TBH_H_START;
            s_next.busy = 1'b1;
            s_next.nack = 1'b0;
            s_next.rd = req_read;
            s_next.sh = {dev_addr, req_read};
            s_next.pend = with_data ? wr_data : 8'h00;
            s_next.left = req_read ? 3'h0 : (with_data ? 3'h2 : 3'h1);
            s_next.rleft = rd_len;
            s_next.long_wait = is_cmd && wr_data == `TBH_CMD_SAVE;
            if (is_cmd && wr_data == `TBH_CMD_SETUP) begin
              s_next.setup_sent = 1'b1;
            end
            if (is_cmd && (wr_data == `TBH_CMD_NORMAL ||
                           wr_data == `TBH_CMD_SWRESET)) begin
              s_next.setup_sent = 1'b0;
            end
            s_next.qcnt = 7'h00;
          end
        end
      end
      TBH_H_HOLD: begin
        s_next.wait_cnt = s_reg.wait_cnt - 32'h1;
        if (s_reg.wait_cnt == 32'h0) begin
          s_next.st = TBH_H_IDLE;
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
      default: begin
        if (tick) begin
          s_next.q = s_reg.q + 2'b01;
          case (s_reg.st)
            TBH_H_START: begin
              if (s_reg.q == 2'b01) s_next.sda_oe = 1'b1;
              if (s_reg.q == 2'b11) begin
                s_next.scl_oe = 1'b1;
                s_next.st = TBH_H_TX;
                s_next.bitc = 4'h0;
              end
            end
            TBH_H_TX, TBH_H_RX: begin
              if (s_reg.q == 2'b00) begin
                s_next.sda_oe = (s_reg.st == TBH_H_TX) && !s_reg.sh[7];
              end
              if (s_reg.q == 2'b01) s_next.scl_oe = 1'b0;
              if (s_reg.q == 2'b10) begin
                s_next.sh = {s_reg.sh[6:0], link.sda};
              end
              if (s_reg.q == 2'b11) begin
                s_next.scl_oe = 1'b1;
                s_next.bitc = s_reg.bitc + 4'h1;
                if (s_reg.bitc == 4'h7) begin
                  s_next.st = (s_reg.st == TBH_H_TX) ? TBH_H_TACK
                                                     : TBH_H_RACK;
                  if (s_reg.st == TBH_H_RX) begin
                    s_next.rbyte = s_reg.sh;
                    s_next.rvalid = 1'b1;
                    s_next.rleft = s_reg.rleft - 4'h1;
                  end
                end
              end
            end
            TBH_H_TACK, TBH_H_RACK: begin
              if (s_reg.q == 2'b00) begin
                // Last read byte is refused so the target lets go
                s_next.sda_oe = (s_reg.st == TBH_H_RACK) &&
                                (s_reg.rleft != 4'h0);
              end
              if (s_reg.q == 2'b01) s_next.scl_oe = 1'b0;
              if (s_reg.q == 2'b10 && s_reg.st == TBH_H_TACK &&
                  link.sda) begin
                s_next.nack = 1'b1;
              end
              if (s_reg.q == 2'b11) begin
                s_next.scl_oe = 1'b1;
                s_next.bitc = 4'h0;
                s_next.st = TBH_H_STOP;
                if (!s_next.nack && s_reg.rd && s_reg.rleft != 4'h0) begin
                  s_next.st = TBH_H_RX;
                end else if (!s_next.nack && s_reg.left != 3'h0) begin
                  s_next.st = TBH_H_TX;
                  s_next.left = s_reg.left - 3'h1;
                  // Pointer always leads the data byte
                  s_next.sh = (s_reg.left == 3'h1 && with_data) ?
                              s_reg.pend : reg_ptr;
                end
              end
            end
            TBH_H_STOP: begin
              if (s_reg.q == 2'b00) s_next.sda_oe = 1'b1;
              if (s_reg.q == 2'b01) s_next.scl_oe = 1'b0;
              if (s_reg.q == 2'b10) s_next.sda_oe = 1'b0;
              if (s_reg.q == 2'b11) begin
                s_next.st = TBH_H_HOLD;
                s_next.wait_cnt = s_reg.long_wait ?
                                  32'(FLASH_WAIT_CYC) : 32'h0;
              end
            end
            default: s_next.st = TBH_H_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_sda_out = 1'b0;
  assign link.host_scl_oe = s_reg.scl_oe;
  assign link.host_sda_oe = s_reg.sda_oe;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign refused = s_reg.refused;
  assign nack_seen = s_reg.nack;
  assign rd_byte = s_reg.rbyte;
  assign rd_valid = s_reg.rvalid;
endmodule

// file: verification/tbh_link_assertions.sv
// Timing and framing checks on the two-wire link between both ends
`timescale 1ns/1ps
module tbh_link_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link wires and open-drain enables
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic [8:0] hi_cnt;
  logic [8:0] lo_cnt;
  logic [3:0] idle_cnt;
  logic [3:0] bit_cnt;
  logic [3:0] byte_cnt;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;

  assign start_seen = scl && scl_q && sda_q && !sda;
  assign stop_seen = scl && scl_q && !sda_q && sda;
  assign scl_rise = scl && !scl_q;

  // Counters saturate so long idle stretches cannot wrap into false fails
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      hi_cnt <= 9'h000;
      lo_cnt <= 9'h000;
      idle_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      byte_cnt <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      hi_cnt <= (!scl) ? 9'h000 : hi_cnt + {8'h00, hi_cnt != 9'h1ff};
      lo_cnt <= scl ? 9'h000 : lo_cnt + {8'h00, lo_cnt != 9'h1ff};
      if (start_seen) begin
        in_frame <= 1'b1;
      end else if (stop_seen) begin
        in_frame <= 1'b0;
      end
      if (in_frame || start_seen) begin
        idle_cnt <= 4'h0;
      end else if (idle_cnt != 4'hf) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
      if (start_seen) begin
        bit_cnt <= 4'h0;
        byte_cnt <= 4'h0;
      end else if (scl_rise && bit_cnt == 4'h8) begin
        bit_cnt <= 4'h0;
        byte_cnt <= byte_cnt + {3'h0, byte_cnt != 4'hf};
      end else if (scl_rise) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_reset_lines_free: assert property (disable iff (1'b0)
    rst && $past(rst) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("link driven low during reset");
  a_scl_high_time: assert property (
    scl_q && !scl |-> hi_cnt >= 9'h01e)
    else $error("clock high phase too short");
  a_scl_low_time: assert property (
    !scl_q && scl |-> lo_cnt >= 9'h041)
    else $error("clock low phase too short");
  a_dev_after_filter: assert property (
    $rose(dev_sda_oe) |-> !scl && lo_cnt >= 9'h004)
    else $error("device drove data before clock fall was filtered");
  a_address_ack: assert property (
    scl_rise && bit_cnt == 4'h8 && byte_cnt == 4'h0 |-> !sda)
    else $error("address byte not acknowledged");
  a_dev_quiet_idle: assert property (
    idle_cnt == 4'hf |-> !dev_sda_oe)
    else $error("device drives data outside a frame");
  a_dev_steady_high: assert property (
    in_frame && scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device data changed while clock high");
  a_data_setup_time: assert property (
    scl_rise |-> sda == $past(sda, 5))
    else $error("data not settled before clock rise");

  c_frame_start: cover property (start_seen);
  c_data_ack: cover property (scl_rise && bit_cnt == 4'h8 && byte_cnt == 4'h2);
  c_dev_read_data: cover property ($rose(dev_sda_oe) && byte_cnt == 4'h1);
  c_frame_stop: cover property (stop_seen);
endmodule

// file: verification/test_touch_button_host_command_port.sv
// Self-checking bench: host and button controller joined on the link
`timescale 1ns/1ps
`include "tbh_regs.svh"
module test_touch_button_host_command_port;
  localparam int FLASH_CYC = 50;
  localparam int LIMIT_CYC = 100000;
  logic clock;
  logic rst;
  logic req;
  logic req_read;
  logic [6:0] dev_addr;
  logic [7:0] reg_ptr;
  logic with_data;
  logic [7:0] wr_data;
  logic [3:0] rd_len;
  logic sleep_rate_unsafe;
  logic busy;
  logic done;
  logic refused;
  logic nack_seen;
  logic [7:0] rd_byte;
  logic rd_valid;
  logic setup_mode;
  logic defaults_pulse;
  logic soft_reset_pulse;
  logic flash_save_pulse;
  logic [7:0] input_config;
  logic [7:0] button_select;
  logic [15:0] baseline;
  logic [15:0] diff_count;
  logic [15:0] raw_count;
  logic [7:0] touch_status;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_swr;
  int n_sav;
  int n_dfl;
  int n_ref;
  int n_cyc;
  int cyc_plain;
  logic [7:0] rd_q[$];
  logic [7:0] cfg_exp;

  tbh_link_if link();
  tbh_host #(.FLASH_WAIT_CYC(FLASH_CYC)) tbh_host_inst (
    .clock(clock), .rst(rst), .link(link), .req(req),
    .req_read(req_read), .dev_addr(dev_addr), .reg_ptr(reg_ptr),
    .with_data(with_data), .wr_data(wr_data), .rd_len(rd_len),
    .sleep_rate_unsafe(sleep_rate_unsafe), .busy(busy), .done(done),
    .refused(refused), .nack_seen(nack_seen), .rd_byte(rd_byte),
    .rd_valid(rd_valid));
  tbh_dev tbh_dev_inst (
    .clock(clock), .rst(rst), .link(link), .setup_mode(setup_mode),
    .defaults_pulse(defaults_pulse), .soft_reset_pulse(soft_reset_pulse),
    .flash_save_pulse(flash_save_pulse), .input_config(input_config),
    .button_select(button_select), .baseline(baseline),
    .diff_count(diff_count), .raw_count(raw_count),
    .touch_status(touch_status));
  tbh_link_checker tbh_link_checker_inst (
    .clock(clock), .rst(rst), .scl(link.scl), .sda(link.sda),
    .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hung transfer would otherwise keep the run going forever
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT_CYC) begin
      miscompares++;
      $display("[ERR] run length expected %0d seen %0d", LIMIT_CYC, cycles);
      finish_test;
    end
  end

  task automatic check8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One host request; req pulsed for one cycle, other inputs held steady until done or refused
  task automatic xfer(input logic rd, input logic [7:0] ptr,
                      input logic wd, input logic [7:0] data,
                      input logic [3:0] len);
    n_swr = 0;
    n_sav = 0;
    n_dfl = 0;
    rd_q.delete();
    @(negedge clock);
    req = 1'b1;
    req_read = rd;
    reg_ptr = ptr;
    with_data = wd;
    wr_data = data;
    rd_len = len;
    // A refusal pulses one edge after req, so watch from the first negedge
    for (n_cyc = 0; n_cyc < 40000; n_cyc++) begin
      @(negedge clock);
      req = 1'b0;
      if (rd_valid === 1'b1) rd_q.push_back(rd_byte);
      if (defaults_pulse === 1'b1) n_dfl++;
      if (soft_reset_pulse === 1'b1) n_swr++;
      if (flash_save_pulse === 1'b1) n_sav++;
      if (done === 1'b1 || refused === 1'b1) break;
    end
    n_ref = (refused === 1'b1) ? 1 : 0;
    check8("busy", 8'h00, {7'h00, busy});
  endtask

  function automatic logic [7:0] exp_byte(input logic [7:0] ptr);
    case (ptr)
      8'h82: return baseline[15:8];
      8'h83: return baseline[7:0];
      8'h84: return diff_count[15:8];
      8'h85: return diff_count[7:0];
      8'h86: return raw_count[15:8];
      8'h87: return raw_count[7:0];
      8'h88: return touch_status;
      8'h06: return cfg_exp;
      default: return 8'h00;
    endcase
  endfunction

  initial begin
    rst = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    dev_addr = `TBH_DEV_ADDR;
    reg_ptr = 8'h00;
    with_data = 1'b0;
    wr_data = 8'h00;
    rd_len = 4'h1;
    sleep_rate_unsafe = 1'b0;
    void'($urandom(3465));
    baseline = 16'($urandom);
    diff_count = 16'($urandom);
    raw_count = 16'($urandom);
    touch_status = 8'($urandom);
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (5) @(negedge clock);
    check8("input_config", `TBH_INCFG_RST, input_config);
    check8("button_select", `TBH_BTNSEL_RST, button_select);
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_SETUP, 4'h1);
    cyc_plain = n_cyc;
    check8("setup_mode", 8'h01, {7'h00, setup_mode});
    check8("nack_seen", 8'h00, {7'h00, nack_seen});
    cfg_exp = 8'h01;
    xfer(1'b0, `TBH_PTR_INCFG, 1'b1, cfg_exp, 4'h1);
    check8("input_config", cfg_exp, input_config);
    sleep_rate_unsafe = 1'b1;
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_SAVE, 4'h1);
    check8("unsafe save refused", 8'h01, 8'(n_ref));
    check8("unsafe save pulses", 8'h00, 8'(n_sav));
    sleep_rate_unsafe = 1'b0;
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_SAVE, 4'h1);
    check8("save pulses", 8'h01, 8'(n_sav));
    check8("save hold-off", 8'h01, 8'(n_cyc >= cyc_plain + FLASH_CYC));
    xfer(1'b0, 8'h87, 1'b0, 8'h00, 4'h1);
    xfer(1'b1, 8'h87, 1'b0, 8'h00, 4'h2);
    check8("read count", 8'h02, 8'(rd_q.size()));
    for (int i = 0; i < 2; i++) begin
      check8("read byte", exp_byte(8'h87 + 8'(i)), rd_q[i]);
    end
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_SWRESET, 4'h1);
    check8("soft reset pulses", 8'h01, 8'(n_swr));
    check8("setup_mode", 8'h00, {7'h00, setup_mode});
    check8("input_config kept", cfg_exp, input_config);
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_SWRESET, 4'h1);
    check8("reset outside setup refused", 8'h01, 8'(n_ref));
    check8("soft reset pulses", 8'h00, 8'(n_swr));
    xfer(1'b0, `TBH_PTR_CMD, 1'b1, `TBH_CMD_DEFAULTS, 4'h1);
    check8("defaults pulses", 8'h01, 8'(n_dfl));
    check8("input_config", `TBH_INCFG_RST, input_config);
    check8("button_select", `TBH_BTNSEL_RST, button_select);
    finish_test;
  end
endmodule
